// ### inc/dir_det_pkg.sv
// Purpose: constants for the direction-change detector register slice
// Assumes: byte-wide register port with 8-bit addresses
// Notes: offsets are the byte addresses of the register port
package dir_det_pkg;
    // =====================================================================
    // register offsets
    localparam logic [7:0] CFG_ADDR = 8'h38;
    localparam logic [7:0] SRC_ADDR = 8'h39;
    localparam logic [7:0] ACK_ADDR = 8'h3a;
    localparam logic [7:0] INNER_LOW_ADDR = 8'h3c;
    localparam logic [7:0] INNER_HIGH_ADDR = 8'h3d;
    localparam logic [7:0] OUTER_LOW_ADDR = 8'h3e;
    localparam logic [7:0] OUTER_HIGH_ADDR = 8'h3f;
    // =====================================================================
    // field positions
    localparam int CFG_CHANGE_IRQ_EN_BIT = 7;
    localparam int CFG_LATCH_EN_BIT = 6;
    localparam int SRC_CHANGE_BIT = 6;
    // =====================================================================
    // reset values and fixed read values
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] SRC_RESET = 8'h00;
    localparam logic [15:0] THS_RESET = 16'h0000;
    localparam logic [7:0] ACK_READ_VALUE = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
endpackage : dir_det_pkg

// ### logic/direction_change_detector_regs.sv
// Purpose: direction detector status, threshold and acknowledge registers
// Assumes: samples arrive as signed 16-bit triples with a one-cycle strobe
// Notes: register port is a simple synchronous byte read/write port
`timescale 1ns/1ps

// Functional notes
// - source register: bit6 change, z y x high/low
// - change flag set when direction differs
// - high flag above outer threshold positive
// - low flag beyond outer threshold negative
// - flag clears below inner threshold
// - all axis flags zero after reset
// - acknowledge read refreshes latched source register
// - acknowledge read data is meaningless
// - inner threshold low and high bytes
// - outer threshold low and high bytes
// - latch enable holds requests until acknowledge
// - change interrupt only when enabled
module direction_change_detector_regs #(
    parameter int DATA_W = 16
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic sample_valid_i,
    input wire logic [DATA_W-1:0] accel_x_i,
    input wire logic [DATA_W-1:0] accel_y_i,
    input wire logic [DATA_W-1:0] accel_z_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic direction_irq_o
);

    // =====================================================================
    // elaboration check
    if (DATA_W != 16) begin : g_width_check
        $error("direction detector serves 16-bit samples only");
    end

    // =====================================================================
    // register state
    // configuration and thresholds, as the host wrote them
    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    logic [15:0] inner_threshold_q;
    logic [15:0] inner_threshold_d;
    logic [15:0] outer_threshold_q;
    logic [15:0] outer_threshold_d;
    // status as the host reads it, change flag on top
    logic [6:0] src_q;
    logic [6:0] src_d;
    // flag pattern of the last sample, feeding the hysteresis
    logic [5:0] level_q;
    logic [5:0] level_d;
    // last non-zero pattern, the direction to compare against
    logic [5:0] last_dir_q;
    logic [5:0] last_dir_d;
    // read port and interrupt
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic irq_q;
    logic irq_d;
    // decoded controls and detection results
    logic latch_request_enable;
    logic direction_change_interrupt_enable;
    logic ack_read;
    logic [5:0] level_new;
    logic change_now;

    // decoded controls from the configuration register
    // latching keeps flags until the acknowledge read
    assign latch_request_enable = cfg_q[dir_det_pkg::CFG_LATCH_EN_BIT];
    // the interrupt output is masked by this bit only
    assign direction_change_interrupt_enable =
        cfg_q[dir_det_pkg::CFG_CHANGE_IRQ_EN_BIT];
    // an acknowledge read is any read strobe at its address
    assign ack_read = reg_rd_i && (reg_addr_i == dir_det_pkg::ACK_ADDR);

    // =====================================================================
    // per-axis hysteresis: bit order z_h z_l y_h y_l x_h x_l
    // one instance per axis; x sits in the low pair, z in the high pair
    logic [DATA_W-1:0] accel_axis [3];
    assign accel_axis[0] = accel_x_i;
    assign accel_axis[1] = accel_y_i;
    assign accel_axis[2] = accel_z_i;
    // each axis sees the registered pattern of its own pair only
    for (genvar a = 0; a < 3; a++) begin : g_axis
        direction_axis_hysteresis #(
            .DATA_W(DATA_W)
        ) axis_u (
            .accel_i(accel_axis[a]),
            .inner_ths_i(inner_threshold_q),
            .outer_ths_i(outer_threshold_q),
            .prev_i(level_q[2*a+:2]),
            .level_o(level_new[2*a+:2])
        );
    end

    // direction change: a non-zero pattern that differs from the last
    // non-zero one; an all-zero pattern names no direction
    always_comb begin
        change_now = (level_new != last_dir_q) && (level_new != 6'h00);
    end

    // =====================================================================
    // configuration and threshold registers
    always_comb begin
        cfg_d = cfg_q;
        inner_threshold_d = inner_threshold_q;
        outer_threshold_d = outer_threshold_q;
        // writes to the status and acknowledge locations are dropped
        if (reg_wr_i) begin
            case (reg_addr_i)
                // top two bits steer interrupt and latching
                dir_det_pkg::CFG_ADDR: begin
                    cfg_d = reg_wdata_i;
                end
                // threshold bytes take effect one at a time, no pairing
                dir_det_pkg::INNER_LOW_ADDR: begin
                    inner_threshold_d[7:0] = reg_wdata_i;
                end
                dir_det_pkg::INNER_HIGH_ADDR: begin
                    inner_threshold_d[15:8] = reg_wdata_i;
                end
                // a sample between two byte writes sees a mixed value
                dir_det_pkg::OUTER_LOW_ADDR: begin
                    outer_threshold_d[7:0] = reg_wdata_i;
                end
                dir_det_pkg::OUTER_HIGH_ADDR: begin
                    outer_threshold_d[15:8] = reg_wdata_i;
                end
                default: begin
                end
            endcase
        end
    end

    // configuration and threshold flip-flops
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            cfg_q <= dir_det_pkg::CFG_RESET;
            inner_threshold_q <= dir_det_pkg::THS_RESET;
            outer_threshold_q <= dir_det_pkg::THS_RESET;
        end else begin
            cfg_q <= cfg_d;
            inner_threshold_q <= inner_threshold_d;
            outer_threshold_q <= outer_threshold_d;
        end
    end

    // =====================================================================
    // status flags, direction memory and interrupt
    always_comb begin
        src_d = src_q;
        level_d = level_q;
        last_dir_d = last_dir_q;
        // acknowledge read releases the latched status
        if (ack_read && latch_request_enable) begin
            src_d = {1'b0, level_q};
        end
        // new measurement: update or accumulate status
        if (sample_valid_i) begin
            level_d = level_new;
            // the last direction only moves on a non-zero pattern
            if (level_new != 6'h00) begin
                last_dir_d = level_new;
            end
            if (latch_request_enable) begin
                // set wins over a same-cycle acknowledge
                src_d = src_d | {change_now, level_new};
            end else begin
                src_d = {change_now, level_new};
            end
        end
        // interrupt follows the change flag when enabled; it is a level,
        // so in latched mode it stays up until the acknowledge read
        irq_d = direction_change_interrupt_enable &&
                src_d[dir_det_pkg::SRC_CHANGE_BIT];
    end

    // status flip-flops; the flags are clear after reset
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            src_q <= dir_det_pkg::SRC_RESET[6:0];
            level_q <= 6'h00;
            last_dir_q <= 6'h00;
            irq_q <= 1'b0;
        end else begin
            src_q <= src_d;
            level_q <= level_d;
            last_dir_q <= last_dir_d;
            irq_q <= irq_d;
        end
    end

    // =====================================================================
    // read data path: data holds until the next read
    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = 1'b0;
        if (reg_rd_i) begin
            rvalid_d = 1'b1;
            case (reg_addr_i)
                dir_det_pkg::CFG_ADDR: rdata_d = cfg_q;
                // unused top bit reads as zero
                dir_det_pkg::SRC_ADDR: rdata_d = {1'b0, src_q};
                dir_det_pkg::ACK_ADDR: begin
                    // the value carries nothing; only the side effect counts
                    rdata_d = dir_det_pkg::ACK_READ_VALUE;
                end
                dir_det_pkg::INNER_LOW_ADDR: begin
                    rdata_d = inner_threshold_q[7:0];
                end
                dir_det_pkg::INNER_HIGH_ADDR: begin
                    rdata_d = inner_threshold_q[15:8];
                end
                dir_det_pkg::OUTER_LOW_ADDR: begin
                    rdata_d = outer_threshold_q[7:0];
                end
                dir_det_pkg::OUTER_HIGH_ADDR: begin
                    rdata_d = outer_threshold_q[15:8];
                end
                // holes in the map read as a fixed value
                default: rdata_d = dir_det_pkg::UNMAPPED_READ_VALUE;
            endcase
        end
    end

    // read port flip-flops
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign reg_rvalid_o = rvalid_q;
    assign direction_irq_o = irq_q;

endmodule : direction_change_detector_regs

// =====================================================================
// hysteresis on one axis
// the high flag sets beyond +outer and the low flag beyond -outer;
// both drop once the sample lies strictly inside +-inner
// between the bands the flag of the sample's sign holds and the
// opposite one drops, so no flag survives a sign change
// an outer threshold below the inner one leaves no holding band:
// keep outer at or above inner for true hysteresis
// purely combinational; the caller registers prev_i
module direction_axis_hysteresis #(
    parameter int DATA_W = 16
) (
    input wire logic [DATA_W-1:0] accel_i,
    input wire logic [DATA_W-1:0] inner_ths_i,
    input wire logic [DATA_W-1:0] outer_ths_i,
    input wire logic [1:0] prev_i,
    output logic [1:0] level_o
);

    // =====================================================================
    // elaboration check
    if (DATA_W < 2) begin : g_width_check
        $error("axis hysteresis needs at least two sample bits");
    end

    // =====================================================================
    // sign-extended sample, thresholds as unsigned magnitudes
    // one extra bit keeps the negated full-scale threshold in range
    logic signed [DATA_W:0] val;
    logic signed [DATA_W:0] inn;
    logic signed [DATA_W:0] out_ths;

    assign val = {accel_i[DATA_W-1], accel_i};
    assign inn = {1'h0, inner_ths_i};
    assign out_ths = {1'h0, outer_ths_i};

    // =====================================================================
    // band decision, bit 1 high flag, bit 0 low flag
    always_comb begin
        level_o = prev_i;
        if (val > out_ths) begin
            level_o = 2'h2;
        end else if (val < -out_ths) begin
            level_o = 2'h1;
        end else if ((val < inn) && (val > -inn)) begin
            level_o = 2'h0;
        end else if (!val[DATA_W]) begin
            level_o[0] = 1'h0; // positive sample drops the low flag
        end else begin
            level_o[1] = 1'h0; // negative sample drops the high flag
        end
    end

endmodule : direction_axis_hysteresis

// ### tb/dir_det_props.sv
// Purpose: port checker for the direction register slice
// Assumes: one clock, synchronous reset
// Notes: bound to the design at the foot of this file
`timescale 1ns/1ps
module dir_det_props #(
    parameter int DATA_W = 16
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic sample_valid_i,
    input wire logic [DATA_W-1:0] accel_x_i,
    input wire logic [DATA_W-1:0] accel_y_i,
    input wire logic [DATA_W-1:0] accel_z_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic reg_rvalid_o,
    input wire logic direction_irq_o,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    logic quiet;
    logic rd_src;
    // idle port cycle, and a status read with no sample behind it
    assign quiet = !sample_valid_i && !reg_wr_i && !reg_rd_i;
    assign rd_src = reg_rd_i && reg_addr_i == dir_det_pkg::SRC_ADDR
        && !sample_valid_i;
    // =====================================================================
    // register port
    rvalid_pulse_a: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read valid missing");
    rvalid_idle_a: assert property (!reg_rd_i |=> !reg_rvalid_o)
        else $error("read valid without read");
    rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved");
    ack_data_a: assert property (reg_rd_i && reg_addr_i ==
        dir_det_pkg::ACK_ADDR |=> reg_rdata_o == dir_det_pkg::ACK_READ_VALUE)
        else $error("ack read data");
    unmapped_read_a: assert property (reg_rd_i && reg_addr_i == 8'h3b
        |=> reg_rdata_o == dir_det_pkg::UNMAPPED_READ_VALUE)
        else $error("unmapped read data");
    inner_ths_a: assert property (reg_wr_i && !reg_rd_i && reg_addr_i ==
        dir_det_pkg::INNER_LOW_ADDR ##1 reg_rd_i && !reg_wr_i && reg_addr_i ==
        dir_det_pkg::INNER_LOW_ADDR |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("inner threshold readback");
    outer_ths_a: assert property (reg_wr_i && !reg_rd_i && reg_addr_i ==
        dir_det_pkg::OUTER_HIGH_ADDR ##1 reg_rd_i && !reg_wr_i && reg_addr_i ==
        dir_det_pkg::OUTER_HIGH_ADDR |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("outer threshold readback");
    src_stable_a: assert property (rd_src ##1 rd_src
        |=> reg_rdata_o == $past(reg_rdata_o))
        else $error("status moved without sample");
    irq_stable_a: assert property (quiet ##1 quiet
        |=> $stable(direction_irq_o))
        else $error("interrupt moved while idle");
    // main scenarios
    cover property (sample_valid_i);
    cover property (direction_irq_o);
    cover property (reg_rd_i && reg_addr_i == dir_det_pkg::ACK_ADDR);
endmodule : dir_det_props
bind direction_change_detector_regs dir_det_props #(.DATA_W(DATA_W))
    props_u (.*);

// ### tb/accel_source_model.sv
// Purpose: acceleration source feeding the register slice
// Assumes: one sample per fire pulse
// Notes: the bus shows inverted data once the sample is gone
`timescale 1ns/1ps
module accel_source_model (
    input wire logic clk_sys_i,
    input wire logic fire_i,
    input wire logic [47:0] xyz_i,
    output logic valid_o,
    output logic [47:0] xyz_o
);
    // start idle with a zero bus
    initial begin
        valid_o = 1'b0;
        xyz_o = 48'h0;
    end
    // one-cycle strobe, stale data inverts on every idle cycle
    always @(posedge clk_sys_i) begin
        valid_o <= fire_i;
        xyz_o <= fire_i ? xyz_i : ~xyz_o;
    end
endmodule : accel_source_model

// ### tb/tb_direction_change_detector_regs.sv
// Purpose: register-level test of the direction register slice
// Assumes: 125 MHz clock, reset held 20 cycles
// Notes: inner threshold 0100, outer 1000
`timescale 1ns/1ps
module tb_direction_change_detector_regs;
    logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, fire = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [47:0] xyz = 48'h0, acc;
    logic [31:0] ths = 32'h1000_0100;
    logic vld, rvalid, irq;
    int num_errors = 0;
    int comparisons = 0;
    // =====================================================================
    // clock, source and design
    always #4 clk = ~clk;
    accel_source_model src_u (.clk_sys_i(clk), .fire_i(fire), .xyz_i(xyz),
        .valid_o(vld), .xyz_o(acc));
    direction_change_detector_regs dut_u (.clk_sys_i(clk), .srst_i(srst),
        .sample_valid_i(vld), .accel_x_i(acc[47:32]),
        .accel_y_i(acc[31:16]), .accel_z_i(acc[15:0]), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .direction_irq_o(irq));
    // =====================================================================
    // tasks
    task final_report;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    task chk(input string name, input logic [7:0] exp, input logic [7:0] s);
        comparisons++;
        if (s !== exp) begin
            num_errors++;
            $display("mismatch %s exp %h seen %h", name, exp, s);
        end
    endtask : chk
    task bus(input logic w, r, input logic [7:0] a, d);
        @(posedge clk);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
    endtask : bus
    task rd8(input logic [7:0] a, exp);
        int n;
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, a, 8'h00);
        #1 n = 0;
        while (rvalid !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1 n++;
        end
        if (n == 4) begin
            num_errors++;
            final_report;
        end
        chk($sformatf("reg %h", a), exp, rdata);
    endtask : rd8
    task smp(input logic [47:0] v, input logic [7:0] e, input logic ei);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        fire <= 1'b1;
        xyz <= v;
        @(posedge clk) fire <= 1'b0;
        repeat (3) @(posedge clk);
        rd8(dir_det_pkg::SRC_ADDR, e);
        chk("irq", {7'h0, ei}, {7'h0, irq});
    endtask : smp
    // =====================================================================
    // tests
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        rd8(dir_det_pkg::SRC_ADDR, dir_det_pkg::SRC_RESET);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 1'b0, 8'(dir_det_pkg::INNER_LOW_ADDR + i), ths[8*i+:8]);
            rd8(8'(dir_det_pkg::INNER_LOW_ADDR + i), ths[8*i+:8]);
        end
        bus(1'b1, 1'b0, dir_det_pkg::CFG_ADDR, 8'h80);
        smp(48'h2000_0000_0000, 8'h42, 1'b1);
        smp(48'h0800_0000_0000, 8'h02, 1'b0);
        smp(48'h0000_e000_0000, 8'h44, 1'b1);
        smp(48'h0, 8'h00, 1'b0);
        $display("test unlatched done");
        bus(1'b1, 1'b0, dir_det_pkg::CFG_ADDR, 8'hc0);
        smp(48'h0000_0000_2000, 8'h60, 1'b1);
        smp(48'h0, 8'h60, 1'b1);
        bus(1'b0, 1'b1, dir_det_pkg::SRC_ADDR, 8'h00);
        rd8(dir_det_pkg::SRC_ADDR, 8'h60);
        rd8(dir_det_pkg::ACK_ADDR, dir_det_pkg::ACK_READ_VALUE);
        rd8(dir_det_pkg::SRC_ADDR, 8'h00);
        bus(1'b1, 1'b0, dir_det_pkg::SRC_ADDR, 8'hff);
        rd8(dir_det_pkg::SRC_ADDR, 8'h00);
        rd8(8'h3b, dir_det_pkg::UNMAPPED_READ_VALUE);
        $display("test latched done");
        bus(1'b1, 1'b0, dir_det_pkg::CFG_ADDR, 8'h00);
        smp(48'h2000_0000_0000, 8'h42, 1'b0);
        $display("test masked done");
        final_report;
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        final_report;
    end
endmodule : tb_direction_change_detector_regs
